/* rtl/sacs_cfg.svh */
// Register offsets, field positions, reset values and timing counts of the conversion sequencer.
`ifndef SACS_CFG_SVH
`define SACS_CFG_SVH

`define SACS_OFF_CONTROL_FIRST   8'h00
`define SACS_OFF_CONTROL_SECOND  8'h01
`define SACS_OFF_CONTROL_THIRD   8'h02
`define SACS_OFF_CONTROL_FOURTH  8'h03
`define SACS_OFF_SAMPLE_CONTROL  8'h04
`define SACS_OFF_CHANNEL         8'h05
`define SACS_OFF_COMMAND         8'h06
`define SACS_OFF_EVENT_CONTROL   8'h07
`define SACS_OFF_IRQ_ENABLES     8'h08
`define SACS_OFF_IRQ_FLAGS       8'h09
`define SACS_OFF_RESULT          8'h0a
`define SACS_OFF_ACTIVE_SEL      8'h0b

`define SACS_CF_ENABLE           0
`define SACS_CF_CONTINUOUS       1
`define SACS_CF_RESOLUTION       2
`define SACS_CF_RUN_HALTED       7
`define SACS_CT_DIV_LSB          0
`define SACS_CT_REF_LSB          4
`define SACS_AS_BUSY             8

`define SACS_RST_REG             16'h0000
`define SACS_MAX_ACCUM_SEL       3'h6

`define SACS_CONV_BASE_CYC       7'h0d
`define SACS_SAMP_BASE_CYC       7'h02

`endif

/* rtl/sacs_pkg.sv */
// Types shared by the conversion sequencer modules.
package sacs_pkg;

   typedef enum logic [1:0]
   {
      SACS_IDLE    = 2'h0,
      SACS_SAMPLE  = 2'h1,
      SACS_CONVERT = 2'h3
   } sacs_state_e;

   typedef logic [6:0] sacs_cyc_t;

endpackage : sacs_pkg

/* rtl/sacs_clock_divide_select_if.sv */
// Signals between the sequencer and its converter-clock prescaler.
`timescale 1ns/1ps
`default_nettype none

interface sacs_clock_divide_select_if;
   logic       clear;
   logic       freeze;
   logic [2:0] div_sel;
   logic       tick;
   logic       adc_clk;

   modport ctl
   (
      output clear,
      output freeze,
      output div_sel,
      input  tick,
      input  adc_clk
   );

   modport clock_divide_select
   (
      input  clear,
      input  freeze,
      input  div_sel,
      output tick,
      output adc_clk
   );
endinterface : sacs_clock_divide_select_if

`default_nettype wire

/* rtl/sacs_prescaler.sv */
// Prescaler deriving the converter clock and its rising-edge tick.
`timescale 1ns/1ps
`default_nettype none

module sacs_prescaler
   import sacs_pkg::*;
#(
   parameter int CNT_W = 8
)
(
   input  wire logic   mclk,
   input  wire logic   rst_n,
   sacs_clock_divide_select_if.clock_divide_select pif
);

   logic [CNT_W:0]   factor;
   logic [CNT_W-1:0] full_m1;
   logic [CNT_W-1:0] half_m1;
   logic [CNT_W-1:0] cnt_q;
   logic             tick_q;
   logic             clk_q;

   assign factor  = (CNT_W+1)'(2) << pif.div_sel;
   assign full_m1 = CNT_W'(factor - 1'b1);
   assign half_m1 = CNT_W'((factor >> 1) - 1'b1);

   // Holding the counter at zero while idle gives every trigger the same start delay.
   always_ff @(posedge mclk)
   begin
      if (!rst_n || pif.clear)
         cnt_q <= '0;
      else if (!pif.freeze)
         cnt_q <= (cnt_q == full_m1) ? '0 : cnt_q + 1'b1;
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n || pif.clear)
         tick_q <= 1'b0;
      else if (!pif.freeze)
         tick_q <= (cnt_q == half_m1);
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n || pif.clear)
         clk_q <= 1'b0;
      else if (!pif.freeze && cnt_q == half_m1)
         clk_q <= 1'b1;
      else if (!pif.freeze && cnt_q == full_m1)
         clk_q <= 1'b0;
   end

   assign pif.tick    = tick_q;
   assign pif.adc_clk = clk_q;

endmodule : sacs_prescaler

`default_nettype wire

/* rtl/sacs_sequencer.sv */
// Conversion sequencer: registers, start control, timing, selection locking and result flag.
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "sacs_cfg.svh"

module sacs_sequencer
   import sacs_pkg::*;
#(
   parameter int ADC_W = 10,
   parameter int ACC_W = 16,
   parameter int CH_W  = 5
)
(
   input  wire logic             mclk,
   input  wire logic             rst_n,
   input  wire logic [7:0]       reg_addr,
   input  wire logic [15:0]      reg_wdata,
   input  wire logic             reg_wr,
   input  wire logic             reg_rd,
   output logic      [15:0]      reg_rdata,
   input  wire logic             event_in,
   input  wire logic             debug_halt,
   input  wire logic             global_irq_en,
   input  wire logic [ADC_W-1:0] conv_data,
   output logic                  irq,
   output logic                  analog_enable,
   output logic                  converter_clk,
   output logic                  sample_hold,
   output logic      [CH_W-1:0]  active_channel,
   output logic      [1:0]       active_reference,
   output logic                  resolution_mode
);

   function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
      hit = (addr == off);
   endfunction : hit

   sacs_clock_divide_select_if pif ();

   sacs_state_e      state_q;
   sacs_cyc_t        cyc_q;
   sacs_cyc_t        samp_end;
   sacs_cyc_t        conv_end;
   logic [6:0]       samp_cnt_q;
   logic [6:0]       samp_last;
   logic [2:0]       accum_eff;
   logic             enable_q;
   logic             continuous_q;
   logic             resolution_q;
   logic             run_halted_q;
   logic [2:0]       accum_sel_q;
   logic [1:0]       ref_shadow_q;
   logic [2:0]       div_sel_q;
   logic [3:0]       sdly_q;
   logic [4:0]       slen_q;
   logic [CH_W-1:0]  chan_shadow_q;
   logic             cmd_q;
   logic             evse_q;
   logic             ie_q;
   logic             flag_q;
   logic [ACC_W-1:0] result_q;
   logic [ACC_W-1:0] acc_q;
   logic [ACC_W-1:0] sum;
   logic [CH_W-1:0]  act_chan_q;
   logic [1:0]       act_ref_q;
   logic             hold_q;
   logic             irq_q;
   logic             aen_q;
   logic [15:0]      rdata_q;
   logic             ev_s1_q;
   logic             ev_s2_q;
   logic             ev_s3_q;
   logic             dbg_s1_q;
   logic             dbg_s2_q;
   logic             halted;
   logic             ev_rise;
   logic             tick;
   logic             last_cyc;
   logic             done;
   logic             lock;
   logic             wr_cmd;
   logic             rd_result;
   logic             wr_clear;

   assign halted    = dbg_s2_q && !run_halted_q;
   assign ev_rise   = ev_s2_q && !ev_s3_q;
   assign tick      = pif.tick && !halted;
   assign samp_end  = `SACS_SAMP_BASE_CYC + 7'(sdly_q) + 7'(slen_q);
   assign conv_end  = `SACS_CONV_BASE_CYC + 7'(sdly_q) + 7'(slen_q);
   assign accum_eff = (accum_sel_q > `SACS_MAX_ACCUM_SEL) ? `SACS_MAX_ACCUM_SEL : accum_sel_q;
   assign samp_last = (7'h01 << accum_eff) - 7'h01;
   assign last_cyc  = enable_q && tick && state_q == SACS_CONVERT && cyc_q == conv_end - 7'h01;
   assign done      = last_cyc && samp_cnt_q == samp_last;
   // The selection unlocks in the final converter cycle so the next conversion takes it up.
   assign lock      = state_q != SACS_IDLE
                      && !(state_q == SACS_CONVERT && cyc_q == conv_end - 7'h01);
   assign sum       = ((samp_cnt_q == 7'h00) ? '0 : acc_q) + ACC_W'(conv_data);
   assign wr_cmd    = reg_wr && hit(reg_addr, `SACS_OFF_COMMAND) && reg_wdata[0];
   assign rd_result = reg_rd && hit(reg_addr, `SACS_OFF_RESULT);
   assign wr_clear  = reg_wr && hit(reg_addr, `SACS_OFF_IRQ_FLAGS) && reg_wdata[0];

   assign pif.clear   = !enable_q || (!cmd_q && state_q == SACS_IDLE);
   assign pif.freeze  = halted;
   assign pif.div_sel = div_sel_q;

   sacs_prescaler #(
      .CNT_W (8)
   ) u_clock_divide_select (
      .mclk  (mclk),
      .rst_n (rst_n),
      .pif   (pif)
   );

   // Event and debug lines come from other logic; halt uses the second stage, the event edge the second and third.
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         ev_s1_q  <= 1'b0;
         ev_s2_q  <= 1'b0;
         ev_s3_q  <= 1'b0;
         dbg_s1_q <= 1'b0;
         dbg_s2_q <= 1'b0;
      end
      else
      begin
         ev_s1_q  <= event_in;
         ev_s2_q  <= ev_s1_q;
         ev_s3_q  <= ev_s2_q;
         dbg_s1_q <= debug_halt;
         dbg_s2_q <= dbg_s1_q;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         enable_q      <= 1'b0;
         continuous_q  <= 1'b0;
         resolution_q  <= 1'b0;
         run_halted_q  <= 1'b0;
         accum_sel_q   <= 3'h0;
         ref_shadow_q  <= 2'h0;
         div_sel_q     <= 3'h0;
         sdly_q        <= 4'h0;
         slen_q        <= 5'h00;
         chan_shadow_q <= '0;
         evse_q        <= 1'b0;
         ie_q          <= 1'b0;
      end
      else if (reg_wr)
      begin
         case (reg_addr)
            `SACS_OFF_CONTROL_FIRST:
            begin
               enable_q     <= reg_wdata[`SACS_CF_ENABLE];
               continuous_q <= reg_wdata[`SACS_CF_CONTINUOUS];
               resolution_q <= reg_wdata[`SACS_CF_RESOLUTION];
               run_halted_q <= reg_wdata[`SACS_CF_RUN_HALTED];
            end
            `SACS_OFF_CONTROL_SECOND: accum_sel_q <= reg_wdata[2:0];
            `SACS_OFF_CONTROL_THIRD:
            begin
               div_sel_q    <= reg_wdata[`SACS_CT_DIV_LSB +: 3];
               ref_shadow_q <= reg_wdata[`SACS_CT_REF_LSB +: 2];
            end
            `SACS_OFF_CONTROL_FOURTH: sdly_q <= reg_wdata[3:0];
            `SACS_OFF_SAMPLE_CONTROL: slen_q <= reg_wdata[4:0];
            `SACS_OFF_CHANNEL:        chan_shadow_q <= reg_wdata[CH_W-1:0];
            `SACS_OFF_EVENT_CONTROL:  evse_q <= reg_wdata[0];
            `SACS_OFF_IRQ_ENABLES:    ie_q <= reg_wdata[0];
            default:                  ie_q <= ie_q;
         endcase
      end
   end

   // Setting by write or event wins over the completion clear of the same cycle.
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         cmd_q <= 1'b0;
      else if (!enable_q)
         cmd_q <= 1'b0;
      else if (wr_cmd || (evse_q && ev_rise))
         cmd_q <= 1'b1;
      else if (done && !continuous_q)
         cmd_q <= 1'b0;
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n || !enable_q)
      begin
         state_q    <= SACS_IDLE;
         cyc_q      <= '0;
         samp_cnt_q <= 7'h00;
      end
      else if (tick)
      begin
         case (state_q)
            SACS_IDLE:
            begin
               if (cmd_q)
               begin
                  state_q    <= SACS_SAMPLE;
                  cyc_q      <= '0;
                  samp_cnt_q <= 7'h00;
               end
            end
            SACS_SAMPLE:
            begin
               cyc_q <= cyc_q + 7'h01;
               if (cyc_q == samp_end - 7'h01)
                  state_q <= SACS_CONVERT;
            end
            SACS_CONVERT:
            begin
               if (cyc_q == conv_end - 7'h01)
               begin
                  cyc_q <= '0;
                  if (samp_cnt_q != samp_last)
                  begin
                     samp_cnt_q <= samp_cnt_q + 7'h01;
                     state_q    <= SACS_SAMPLE;
                  end
                  else if (continuous_q && cmd_q)
                  begin
                     samp_cnt_q <= 7'h00;
                     state_q    <= SACS_SAMPLE;
                  end
                  else
                     state_q <= SACS_IDLE;
               end
               else
                  cyc_q <= cyc_q + 7'h01;
            end
            default:
               state_q <= SACS_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         acc_q    <= '0;
         result_q <= '0;
      end
      else if (last_cyc)
      begin
         acc_q <= sum;
         if (done)
            result_q <= sum;
      end
   end

   // The flag is left alone by a disable, so a finished result survives an abort.
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         flag_q <= 1'b0;
      else if (done)
         flag_q <= 1'b1;
      else if (rd_result || wr_clear)
         flag_q <= 1'b0;
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         act_chan_q <= '0;
         act_ref_q  <= 2'h0;
      end
      else if (enable_q && !lock)
      begin
         act_chan_q <= chan_shadow_q;
         act_ref_q  <= ref_shadow_q;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         hold_q <= 1'b0;
         irq_q  <= 1'b0;
         aen_q  <= 1'b0;
      end
      else
      begin
         hold_q <= enable_q && state_q == SACS_SAMPLE;
         irq_q  <= flag_q && ie_q && global_irq_en;
         aen_q  <= enable_q;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n || !reg_rd)
         rdata_q <= `SACS_RST_REG;
      else
      begin
         case (reg_addr)
            `SACS_OFF_CONTROL_FIRST:  rdata_q <= {8'h00, run_halted_q, 4'h0, resolution_q, continuous_q, enable_q};
            `SACS_OFF_CONTROL_SECOND: rdata_q <= {13'h0000, accum_sel_q};
            `SACS_OFF_CONTROL_THIRD:  rdata_q <= {10'h000, ref_shadow_q, 1'b0, div_sel_q};
            `SACS_OFF_CONTROL_FOURTH: rdata_q <= {12'h000, sdly_q};
            `SACS_OFF_SAMPLE_CONTROL: rdata_q <= {11'h000, slen_q};
            `SACS_OFF_CHANNEL:        rdata_q <= 16'(chan_shadow_q);
            `SACS_OFF_COMMAND:        rdata_q <= {15'h0000, cmd_q};
            `SACS_OFF_EVENT_CONTROL:  rdata_q <= {15'h0000, evse_q};
            `SACS_OFF_IRQ_ENABLES:    rdata_q <= {15'h0000, ie_q};
            `SACS_OFF_IRQ_FLAGS:      rdata_q <= {15'h0000, flag_q};
            `SACS_OFF_RESULT:         rdata_q <= 16'(result_q);
            `SACS_OFF_ACTIVE_SEL:     rdata_q <= 16'({lock, 1'b0, act_ref_q, act_chan_q});
            default:                  rdata_q <= `SACS_RST_REG;
         endcase
      end
   end

   assign reg_rdata        = rdata_q;
   assign irq              = irq_q;
   assign analog_enable    = aen_q;
   assign converter_clk    = pif.adc_clk;
   assign sample_hold      = hold_q;
   assign active_channel   = act_chan_q;
   assign active_reference = act_ref_q;
   assign resolution_mode  = resolution_q;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   chk_idle_when_off: assert property (!enable_q |=> state_q == SACS_IDLE && !cmd_q)
      else $error("converter active while disabled");
   chk_result_ten_bit: assert property (done && accum_eff == 3'h0 |=> result_q[ACC_W-1:ADC_W] == '0)
      else $error("single result wider than ten bits");
   chk_halt_freezes: assert property (halted && state_q != SACS_IDLE |=> $stable(cyc_q) && $stable(state_q))
      else $error("sequencer advanced while halted");
   chk_cmd_single_clr: assert property (done && !continuous_q && !wr_cmd && !ev_rise |=> !cmd_q)
      else $error("start bit not cleared at completion");
   chk_flag_on_done: assert property (done |=> flag_q ##1 (irq_q == ($past(ie_q) && $past(global_irq_en))))
      else $error("ready flag or request missing after completion");
   chk_event_start: assert property (enable_q && evse_q && ev_rise |=> cmd_q)
      else $error("event edge did not set start bit");
   chk_free_restart: assert property (done && continuous_q && cmd_q && enable_q |=> state_q == SACS_SAMPLE)
      else $error("free-running restart missing");
   chk_clock_divide_select_off: assert property (!enable_q |=> !tick ##1 !tick)
      else $error("prescaler ticked while disabled");
   chk_sel_locked: assert property (enable_q && lock |=> $stable(act_chan_q) && $stable(act_ref_q))
      else $error("active selection moved during conversion");
   chk_read_clears: assert property (rd_result && !done |=> !flag_q)
      else $error("result read did not clear flag");
   chk_irq_drops: assert property (!flag_q |=> !irq_q)
      else $error("request without flag");
   chk_abort_keeps: assert property ($fell(enable_q) |=> $stable(result_q) && state_q == SACS_IDLE)
      else $error("abort changed result or left sequencer busy");

endmodule : sacs_sequencer

`default_nettype wire

/* verif/sacs_event_src.sv */
// Event routing model that registers each request and passes it on as the event pulse one cycle later.
`timescale 1ns/1ps
`default_nettype none

module sacs_event_src
(
   input  wire logic mclk,
   input  wire logic fire,
   output var logic  event_out
);
   // A one-cycle pulse gives exactly one rising edge, so no start is lost or doubled.
   initial event_out = 1'b0;
   always @(posedge mclk) event_out <= fire;
endmodule : sacs_event_src

`default_nettype wire

/* verif/tb.sv */
// Self-checking testbench of the conversion sequencer against a behavioural result model.
`timescale 1ns/1ps
`default_nettype none
`include "sacs_cfg.svh"

module tb;
   import sacs_pkg::*;

   localparam logic [7:0] a_cf1 = `SACS_OFF_CONTROL_FIRST;
   localparam logic [7:0] a_cmd = `SACS_OFF_COMMAND;
   localparam logic [7:0] a_flg = `SACS_OFF_IRQ_FLAGS;
   localparam logic [7:0] a_res = `SACS_OFF_RESULT;

   logic        mclk, rst_n, reg_wr, reg_rd, event_fire, event_in, debug_halt, global_irq_en;
   logic        irq, analog_enable, converter_clk, sample_hold, resolution_mode, cc;
   logic [7:0]  reg_addr;
   logic [15:0] reg_wdata, reg_rdata, rd_q;
   logic [9:0]  conv_data;
   logic [4:0]  active_channel;
   logic [1:0]  active_reference;
   int          n_errors, n_checks, sel, fac, sdly, slen, ch, ch2, rf, v, n, hi;
   int          mq[$];

   sacs_sequencer u_sacs_sequencer
   (
      .mclk             (mclk),
      .rst_n            (rst_n),
      .reg_addr         (reg_addr),
      .reg_wdata        (reg_wdata),
      .reg_wr           (reg_wr),
      .reg_rd           (reg_rd),
      .reg_rdata        (reg_rdata),
      .event_in         (event_in),
      .debug_halt       (debug_halt),
      .global_irq_en    (global_irq_en),
      .conv_data        (conv_data),
      .irq              (irq),
      .analog_enable    (analog_enable),
      .converter_clk    (converter_clk),
      .sample_hold      (sample_hold),
      .active_channel   (active_channel),
      .active_reference (active_reference),
      .resolution_mode  (resolution_mode)
   );

   sacs_event_src u_sacs_event_src
   (
      .mclk      (mclk),
      .fire      (event_fire),
      .event_out (event_in)
   );

   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e)
      begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", s, e, g);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr

   // Read data stand only in the cycle after the strobe, so they are taken right there.
   task automatic rd(input logic [7:0] a);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      rd_q = reg_rdata;
   endtask : rd

   task automatic cyc(input int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask : cyc

   task automatic until_sh(input logic lv, output int k);
      k = 0;
      while (sample_hold !== lv && k < 9000)
      begin
         @(posedge mclk);
         #1;
         k++;
      end
      if (sample_hold !== lv)
         n_errors++;
   endtask : until_sh

   task automatic wait_flag;
      int k;
      k = 0;
      rd(a_flg);
      while (rd_q[0] !== 1'b1 && k < 5000)
      begin
         rd(a_flg);
         k++;
      end
   endtask : wait_flag

   // The converter word is only changed at an edge, one sample pushed per expected conversion.
   task automatic setv(input int cnt);
      @(posedge mclk);
      v = $urandom % 1024;
      conv_data <= 10'(v);
      repeat (cnt) mq.push_back(v);
   endtask : setv

   function automatic int msum();
      int s;
      s = 0;
      foreach (mq[i]) s += mq[i];
      mq.delete();
      return s;
   endfunction : msum

   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : end_sim

   initial
   begin
      repeat (90000) @(posedge mclk);
      n_errors++;
      end_sim;
   end

   initial
   begin
      rst_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
      event_fire = 1'b0;
      debug_halt = 1'b0;
      global_irq_en = 1'b0;
      conv_data = 10'h000;
      n_errors = 0;
      n_checks = 0;
      void'($urandom(32'h26d12481));
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      for (int a = 0; a < 13; a++)
      begin
         rd(8'(a));
         chk("reset read", 16'h0000, rd_q);
      end
      wr(8'h20, 16'hffff);
      rd(8'h20);
      chk("unmapped", 16'h0000, rd_q);
      $display("test reset done");
      // Dividers of 32 and 64 keep the converter clock inside the full-resolution range.
      sel = 4 + $urandom % 2;
      fac = 2 << sel;
      sdly = $urandom % 8;
      slen = $urandom % 8;
      ch = 1 + $urandom % 31;
      rf = $urandom % 4;
      wr(a_cf1, 16'h0004);
      wr(`SACS_OFF_CONTROL_THIRD, 16'(rf * 16 + sel));
      wr(`SACS_OFF_CONTROL_FOURTH, 16'(sdly));
      wr(`SACS_OFF_SAMPLE_CONTROL, 16'(slen));
      wr(`SACS_OFF_CHANNEL, 16'(ch));
      wr(`SACS_OFF_IRQ_ENABLES, 16'h0001);
      cyc(2);
      chk("chan before enable", 16'h0000, 16'(active_channel));
      wr(a_cf1, 16'h0005);
      cyc(3);
      chk("chan", 16'(ch), 16'(active_channel));
      chk("ref", 16'(rf), 16'(active_reference));
      chk("enable", 16'h0001, 16'(analog_enable));
      chk("res mode", 16'h0001, 16'(resolution_mode));
      chk("clk idle", 16'h0000, 16'(converter_clk));
      setv(1);
      wr(a_cmd, 16'h0001);
      until_sh(1'b1, n);
      chk("start delay", 16'(fac / 2 + 2), 16'(n));
      until_sh(1'b0, n);
      chk("sample width", 16'((2 + sdly + slen) * fac), 16'(n));
      rd(a_cmd);
      chk("cmd busy", 16'h0001, rd_q);
      ch2 = ch ^ 1;
      wr(`SACS_OFF_CHANNEL, 16'(ch2));
      cyc(2);
      chk("chan locked", 16'(ch), 16'(active_channel));
      wait_flag;
      chk("flag", 16'h0001, rd_q);
      chk("irq gated", 16'h0000, 16'(irq));
      rd(a_cmd);
      chk("cmd done", 16'h0000, rd_q);
      chk("chan follows", 16'(ch2), 16'(active_channel));
      rd(a_res);
      chk("result", 16'(msum()), rd_q);
      rd(a_flg);
      chk("flag read clear", 16'h0000, rd_q);
      $display("test single done");
      @(posedge mclk);
      global_irq_en <= 1'b1;
      wr(`SACS_OFF_EVENT_CONTROL, 16'h0001);
      setv(1);
      event_fire <= 1'b1;
      @(posedge mclk);
      event_fire <= 1'b0;
      cyc(6);
      rd(a_cmd);
      chk("cmd event", 16'h0001, rd_q);
      wait_flag;
      cyc(2);
      chk("irq on", 16'h0001, 16'(irq));
      rd(a_cmd);
      chk("cmd event done", 16'h0000, rd_q);
      chk("irq held", 16'h0001, 16'(irq));
      wr(a_flg, 16'h0001);
      cyc(2);
      chk("irq off", 16'h0000, 16'(irq));
      rd(a_flg);
      chk("flag w1 clear", 16'h0000, rd_q);
      rd(a_res);
      chk("event result", 16'(msum()), rd_q);
      wr(`SACS_OFF_EVENT_CONTROL, 16'h0000);
      $display("test event done");
      setv(1);
      wr(a_cmd, 16'h0001);
      until_sh(1'b1, n);
      @(posedge mclk);
      debug_halt <= 1'b1;
      cyc(6);
      cc = converter_clk;
      cyc(3 * fac);
      chk("halt clk", 16'(cc), 16'(converter_clk));
      chk("halt sample", 16'h0001, 16'(sample_hold));
      @(posedge mclk);
      debug_halt <= 1'b0;
      wait_flag;
      rd(a_res);
      chk("halt result", 16'(msum()), rd_q);
      wr(a_cf1, 16'h0085);
      debug_halt <= 1'b1;
      mq.push_back(v);
      wr(a_cmd, 16'h0001);
      wait_flag;
      chk("run halted", 16'h0001, rd_q);
      @(posedge mclk);
      debug_halt <= 1'b0;
      rd(a_res);
      chk("run halted result", 16'(msum()), rd_q);
      $display("test debug done");
      wr(a_cf1, 16'h0007);
      wr(a_cmd, 16'h0001);
      until_sh(1'b1, n);
      until_sh(1'b0, hi);
      until_sh(1'b1, n);
      chk("period", 16'((13 + sdly + slen) * fac), 16'(hi + n));
      rd(a_flg);
      chk("free flag", 16'h0001, rd_q);
      wr(a_flg, 16'h0001);
      wr(`SACS_OFF_CHANNEL, 16'(ch));
      cyc(1);
      chk("free chan locked", 16'(ch2), 16'(active_channel));
      until_sh(1'b0, n);
      until_sh(1'b1, n);
      chk("free chan next", 16'(ch), 16'(active_channel));
      rd(a_flg);
      chk("free flag again", 16'h0001, rd_q);
      rd(a_cmd);
      chk("free cmd", 16'h0001, rd_q);
      $display("test free-running done");
      wr(a_flg, 16'h0001);
      rd(a_res);
      chk("free result", 16'(v), rd_q);
      @(posedge mclk);
      conv_data <= 10'(v ^ 1);
      wr(a_cf1, 16'h0000);
      cyc(3);
      chk("abort enable", 16'h0000, 16'(analog_enable));
      chk("abort clk", 16'h0000, 16'(converter_clk));
      chk("abort sample", 16'h0000, 16'(sample_hold));
      rd(a_cmd);
      chk("abort cmd", 16'h0000, rd_q);
      rd(a_flg);
      chk("abort flag", 16'h0000, rd_q);
      rd(a_res);
      chk("abort result", 16'(v), rd_q);
      $display("test abort done");
      wr(`SACS_OFF_CONTROL_SECOND, 16'h0002);
      wr(a_cf1, 16'h0001);
      setv(4);
      wr(a_cmd, 16'h0001);
      repeat (4)
      begin
         until_sh(1'b1, n);
         until_sh(1'b0, n);
      end
      rd(a_flg);
      chk("accum flag early", 16'h0000, rd_q);
      wait_flag;
      chk("accum flag", 16'h0001, rd_q);
      rd(a_res);
      chk("accum result", 16'(msum()), rd_q);
      $display("test accumulate done");
      end_sim;
   end
endmodule : tb

`default_nettype wire
